/* File: hdl/qawd_top.sv */
// Question-and-answer watchdog sequencer: windows, answer checking and failure tally.
// Operation
// RULE1 - The question is a four-bit value.
// RULE2 - Question read counts only for a fault-free serial read frame.
// RULE3 - Multi-answer mode takes four answer bytes forming one 32-bit answer.
// RULE4 - Host sends three bytes in window one, the last in window two.
// RULE5 - Answer index loads 3 at window one entry, decrements per byte.
// RULE6 - Single-answer mode takes one byte in open window, index stays 1.
// RULE7 - New run on time-out, configuration change, or final answer byte.
// RULE8 - Multi run is window one then two; configurable only in diagnostic state.
// RULE9 - Window one lasts (first length + 1) times 0.55 ms.
// RULE10 - Window two lasts (second length + 1) times 0.55 ms.
// RULE11 - Single run is closed then open window; configurable only in diagnostic.
// RULE12 - Closed window lasts (first length field + 1) times 0.55 ms.
// RULE13 - Open window lasts (second length field + 1) times 0.55 ms.
// RULE14 - The 0.55 ms step is counted from the system clock.
// RULE15 - After the lock command, window configuration writes are blocked.
// RULE16 - Multi mode: next question within one clock after final byte; the code renews it only if all four bytes were correct and in window.
// RULE17 - Single mode: next question within one clock after correct byte.
// RULE18 - Interleaved other frames and question reads do not disturb checking.
// RULE19 - Host writes nothing in closed window, one correct byte in open.
// RULE20 - Question chain state zero is forced to one next.
// RULE21 - Current question is latched and readable at any time.
// RULE22 - Expected byte picked by question and answer index, index 3 first.
// RULE23 - Tally down on correct, up on wrong, time-out or configuration change.
// RULE24 - Tally saturates at 0xF and at 0x0.
// RULE25 - Windows elapsing without complete answer set the time-out flag.
// RULE26 - Expected answers come from a lookup table by question and index.
// RULE27 - Each byte is compared with the table; result drives tally and flags.
`timescale 1ns/1ps
`default_nettype none
module qawd_top
  import qawd_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = QAWD_STEP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic SPI_SCLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE,
  input wire logic DIAG_STATE,
  input wire logic CFG_WR,
  input wire logic CFG_MODE_SINGLE,
  input wire logic [7:0] CFG_FIRST_LEN,
  input wire logic [4:0] CFG_SECOND_LEN,
  input wire logic SOFTWARE_WRITE_LOCK_CMD_CMD,
  input wire logic STATUS_CLR,
  output logic [3:0] QUESTION,
  output logic [1:0] ANSWER_INDEX,
  output logic [3:0] FAIL_TALLY,
  output logic FLAG_ANSW_ERR,
  output logic FLAG_ANSW_EARLY,
  output logic FLAG_SEQ_ERR,
  output logic FLAG_TIME_OUT,
  output logic IN_SECOND_WINDOW,
  output logic MODE_SINGLE,
  output logic CFG_LOCKED,
  output logic [7:0] FIRST_LEN,
  output logic [4:0] SECOND_LEN,
  output logic RUN_START,
  output logic QREAD_EVT,
  output logic SPI_FAULT
);
  typedef struct packed {
    qawd_phase_e phase_r;
    logic [QAWD_STEP_W-1:0] step_r;
    logic [7:0] wsteps_r;
    logic [1:0] cnt_r;
    logic bad_r;
    logic single_r;
    logic lock_r;
    logic [7:0] first_r;
    logic [4:0] second_r;
    logic [3:0] tally_r;
    logic f_err_r;
    logic f_early_r;
    logic f_seq_r;
    logic f_to_r;
    logic start_r;
  } qawd_top_s;

  localparam logic [QAWD_STEP_W-1:0] STEP_LAST = QAWD_STEP_W'(STEP_CYCLES - 1);

  logic rst_m;
  logic rst_n;
  qawd_top_s s_r;
  qawd_top_s s_nxt;
  logic ans_evt;
  logic [7:0] ans_byte;
  logic [7:0] expected;
  logic [3:0] question;
  logic tick;
  logic win_end;
  logic cfg_ok;
  logic cfg_chg;
  logic good;
  logic restart;
  logic inc;
  logic dec;
  logic advance;
  logic set_err;
  logic set_early;
  logic set_seq;
  logic set_to;

  // Reset release passes two flops; assertion stays asynchronous.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Serial frames; other frames between answer bytes just produce no answer event.
  qawd_spi_rx u_spi (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .sclk(SPI_SCLK),
    .cs_n(SPI_CS_N),
    .mosi(SPI_MOSI),
    .question(question),
    .miso(SPI_MISO),
    .miso_oe(SPI_MISO_OE),
    .qread_evt(QREAD_EVT),
    .ans_evt(ans_evt),
    .ans_byte(ans_byte),
    .fault_evt(SPI_FAULT)
  );

  // Question chain and expected-byte table.
  qawd_qgen u_qgen (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .advance(advance),
    .ans_index(s_r.cnt_r),
    .question(question),
    .expected(expected)
  );

  // Sequencer: configuration first, then answer bytes, then window time-out.
  always_comb begin
    s_nxt = s_r;
    s_nxt.start_r = 1'b0;
    restart = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    advance = 1'b0;
    set_err = 1'b0;
    set_early = 1'b0;
    set_seq = 1'b0;
    set_to = 1'b0;
    tick = (s_r.step_r == STEP_LAST); // RULE14
    s_nxt.step_r = tick ? '0 : s_r.step_r + 1'b1;
    win_end = tick && (s_r.phase_r == QAWD_PH_FIRST ? s_r.wsteps_r == s_r.first_r // RULE9 RULE12
                                                    : s_r.wsteps_r == {3'h0, s_r.second_r}); // RULE10 RULE13
    if (tick) begin
      s_nxt.wsteps_r = s_r.wsteps_r + 8'h01;
    end
    cfg_ok = CFG_WR & DIAG_STATE & ~s_r.lock_r; // RULE8 RULE11 RULE15
    cfg_chg = cfg_ok && (CFG_MODE_SINGLE != s_r.single_r || CFG_FIRST_LEN != s_r.first_r
                         || CFG_SECOND_LEN != s_r.second_r);
    good = (ans_byte == expected); // RULE27
    if (SOFTWARE_WRITE_LOCK_CMD_CMD) begin
      s_nxt.lock_r = 1'b1; // RULE15
    end
    if (cfg_chg) begin
      s_nxt.single_r = CFG_MODE_SINGLE;
      s_nxt.first_r = CFG_FIRST_LEN;
      s_nxt.second_r = CFG_SECOND_LEN;
      restart = 1'b1; // RULE7
      inc = 1'b1; // RULE23
    end else if (ans_evt && s_r.single_r) begin
      if (s_r.phase_r == QAWD_PH_FIRST) begin
        s_nxt.bad_r = 1'b1; // RULE19
        set_early = 1'b1;
      end else begin
        restart = 1'b1; // RULE7
        set_err = ~good;
        if (good && !s_r.bad_r) begin
          dec = 1'b1;
          advance = 1'b1; // RULE17
        end else begin
          inc = 1'b1;
        end
      end
    end else if (ans_evt) begin
      // Three bytes belong to window one and the last to window two.
      s_nxt.cnt_r = s_r.cnt_r - 2'h1; // RULE3 RULE5
      if (!good) begin
        s_nxt.bad_r = 1'b1;
        set_err = 1'b1;
      end
      if (s_r.phase_r == QAWD_PH_FIRST && s_r.cnt_r == QAWD_CNT_LAST) begin
        s_nxt.bad_r = 1'b1; // RULE4
        set_early = 1'b1;
      end
      if (s_r.phase_r == QAWD_PH_SECOND && s_r.cnt_r != QAWD_CNT_LAST) begin
        s_nxt.bad_r = 1'b1; // RULE4 RULE18
        set_seq = 1'b1;
      end
      if (s_r.cnt_r == QAWD_CNT_LAST) begin
        restart = 1'b1; // RULE7
        if (good && !s_r.bad_r && s_r.phase_r == QAWD_PH_SECOND) begin
          dec = 1'b1;
          advance = 1'b1; // RULE16
        end else begin
          inc = 1'b1;
        end
      end
    end // A window end still counts beside a non-final byte.
    if (win_end && !restart && s_r.phase_r == QAWD_PH_FIRST) begin
      s_nxt.phase_r = QAWD_PH_SECOND;
      s_nxt.wsteps_r = 8'h00;
    end else if (win_end && !restart) begin
      restart = 1'b1; // RULE7
      inc = 1'b1; // RULE23
      set_to = 1'b1; // RULE25
      set_seq = ~s_r.single_r;
    end
    if (restart) begin
      s_nxt.phase_r = QAWD_PH_FIRST;
      s_nxt.step_r = '0;
      s_nxt.wsteps_r = 8'h00;
      s_nxt.bad_r = 1'b0;
      s_nxt.cnt_r = s_nxt.single_r ? QAWD_CNT_SINGLE : QAWD_CNT_MULTI; // RULE5 RULE6
      s_nxt.start_r = 1'b1;
    end
    if (inc && s_r.tally_r != QAWD_TALLY_MAX) begin
      s_nxt.tally_r = s_r.tally_r + 4'h1; // RULE23 RULE24
    end else if (dec && s_r.tally_r != QAWD_TALLY_MIN) begin
      s_nxt.tally_r = s_r.tally_r - 4'h1; // RULE23 RULE24
    end
    // Sticky flags: a set in the clearing cycle wins.
    s_nxt.f_err_r = set_err | (s_r.f_err_r & ~STATUS_CLR);
    s_nxt.f_early_r = set_early | (s_r.f_early_r & ~STATUS_CLR);
    s_nxt.f_seq_r = set_seq | (s_r.f_seq_r & ~STATUS_CLR);
    s_nxt.f_to_r = set_to | (s_r.f_to_r & ~STATUS_CLR); // RULE25
  end

  // State register.
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{phase_r: QAWD_PH_FIRST, step_r: '0, wsteps_r: 8'h00, cnt_r: QAWD_CNT_MULTI,
               bad_r: 1'b0, single_r: 1'b0, lock_r: 1'b0, first_r: QAWD_WIN1_RST,
               second_r: QAWD_WIN2_RST, tally_r: QAWD_TALLY_RST, f_err_r: 1'b0,
               f_early_r: 1'b0, f_seq_r: 1'b0, f_to_r: 1'b0, start_r: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state.
  assign QUESTION = question; // RULE21
  assign ANSWER_INDEX = s_r.cnt_r;
  assign FAIL_TALLY = s_r.tally_r;
  assign FLAG_ANSW_ERR = s_r.f_err_r;
  assign FLAG_ANSW_EARLY = s_r.f_early_r;
  assign FLAG_SEQ_ERR = s_r.f_seq_r;
  assign FLAG_TIME_OUT = s_r.f_to_r;
  assign IN_SECOND_WINDOW = (s_r.phase_r == QAWD_PH_SECOND);
  assign MODE_SINGLE = s_r.single_r;
  assign CFG_LOCKED = s_r.lock_r;
  assign FIRST_LEN = s_r.first_r;
  assign SECOND_LEN = s_r.second_r;
  assign RUN_START = s_r.start_r;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  sequence s_first_ends;
    s_r.phase_r == QAWD_PH_FIRST && win_end && !ans_evt && !cfg_chg;
  endsequence
  sequence s_second_ends;
    s_r.phase_r == QAWD_PH_SECOND && win_end && !ans_evt && !cfg_chg;
  endsequence

  property p_first_to_second;
    s_first_ends |=> s_r.phase_r == QAWD_PH_SECOND && s_r.wsteps_r == 8'h00;
  endproperty
  a_first_to_second: assert property (p_first_to_second) else $error("window one end missed"); // RULE9

  property p_timeout;
    s_second_ends |=> FLAG_TIME_OUT && RUN_START && s_r.phase_r == QAWD_PH_FIRST;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out not flagged"); // RULE25

  property p_cnt_load;
    RUN_START && !s_r.single_r |-> s_r.cnt_r == 2'h3;
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("index not loaded with 3"); // RULE5

  property p_cnt_dec;
    ans_evt && !s_r.single_r && s_r.cnt_r != 2'h0 && !cfg_chg |=> s_r.cnt_r == $past(s_r.cnt_r) - 2'h1;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("index did not step down"); // RULE5

  property p_single_cnt;
    s_r.single_r |-> s_r.cnt_r == 2'h1;
  endproperty
  a_single_cnt: assert property (p_single_cnt) else $error("single index not 1"); // RULE6

  property p_next_question;
    advance |=> QUESTION != $past(QUESTION) && RUN_START;
  endproperty
  a_next_question: assert property (p_next_question) else $error("question not renewed"); // RULE16

  property p_zero_state;
    advance && QUESTION == 4'h0 |=> QUESTION == 4'h1;
  endproperty
  a_zero_state: assert property (p_zero_state) else $error("zero state not forced"); // RULE20

  property p_lock;
    s_r.lock_r |=> $stable(s_r.first_r) && $stable(s_r.second_r) && $stable(s_r.single_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked window changed"); // RULE15

  property p_tally_top;
    inc && s_r.tally_r == 4'hF |=> s_r.tally_r == 4'hF;
  endproperty
  a_tally_top: assert property (p_tally_top) else $error("tally wrapped high"); // RULE24

  property p_tally_down;
    dec && s_r.tally_r != 4'h0 |=> s_r.tally_r == $past(s_r.tally_r) - 4'h1;
  endproperty
  a_tally_down: assert property (p_tally_down) else $error("tally not decremented"); // RULE23

  property p_step_bound;
    s_r.step_r <= STEP_LAST;
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("step counter overrun"); // RULE14
endmodule
`default_nettype wire

/* File: hdl/qawd_pkg.sv */
// Shared constants, types and answer table of the question-and-answer watchdog sequencer.
package qawd_pkg;
  // System clock period and the window time step.
  localparam int unsigned QAWD_CLK_NS = 8;
  localparam int unsigned QAWD_STEP_NS = 550000;
  localparam int unsigned QAWD_STEP_CYC = QAWD_STEP_NS / QAWD_CLK_NS;
  localparam int unsigned QAWD_STEP_W = 17;

  // Reset values.
  localparam logic [3:0] QAWD_TALLY_RST = 4'h5;
  localparam logic [3:0] QAWD_QUESTION_RST = 4'h0;
  localparam logic [7:0] QAWD_WIN1_RST = 8'h0F;
  localparam logic [4:0] QAWD_WIN2_RST = 5'h07;

  // Answer index loads and tally limits.
  localparam logic [1:0] QAWD_CNT_MULTI = 2'h3;
  localparam logic [1:0] QAWD_CNT_SINGLE = 2'h1;
  localparam logic [1:0] QAWD_CNT_LAST = 2'h0;
  localparam logic [3:0] QAWD_TALLY_MAX = 4'hF;
  localparam logic [3:0] QAWD_TALLY_MIN = 4'h0;

  // Serial frame layout: write flag, 7-bit address, 8-bit data.
  localparam logic [4:0] QAWD_FRAME_BITS = 5'h10;
  localparam logic [4:0] QAWD_HDR_BITS = 5'h08;
  localparam int unsigned QAWD_WR_BIT = 7;
  localparam logic [6:0] QAWD_ADDR_QUESTION = 7'h01;
  localparam logic [6:0] QAWD_ADDR_ANSWER = 7'h02;

  // Window phase of a run.
  typedef enum logic [0:0] {
    QAWD_PH_FIRST = 1'b0,
    QAWD_PH_SECOND = 1'b1
  } qawd_phase_e;

  // Expected bytes per question; byte lane n belongs to answer index n.
  localparam logic [31:0] QAWD_ANS_TBL [16] = '{
    32'hFF0FF000, 32'hB040BF4F, 32'hE919E616, 32'hA656A959,
    32'h75857A8A, 32'h3ACA35C5, 32'h63936C9C, 32'h2CDC23D3,
    32'hD222DD2D, 32'h9D6D9262, 32'hC434CB3B, 32'h8B7B8474,
    32'h58A857A7, 32'h17E718E8, 32'h4EBE41B1, 32'h01F10EFE
  };
endpackage

/* File: hdl/qawd_qgen.sv */
// Question generator and expected-answer lookup.
`timescale 1ns/1ps
`default_nettype none
module qawd_qgen
  import qawd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire logic [1:0] ans_index,
  output logic [3:0] question,
  output logic [7:0] expected
);
  typedef struct packed {
    logic [3:0] question_r;
  } qawd_qgen_s;

  qawd_qgen_s s_r;
  qawd_qgen_s s_nxt;

  // Four-bit chain steps on each advance; the all-zero state is forced to one.
  always_comb begin
    s_nxt = s_r;
    if (advance) begin
      if (s_r.question_r == 4'h0) begin
        s_nxt.question_r = 4'h1; // RULE20
      end else begin
        s_nxt.question_r = {s_r.question_r[2:0], s_r.question_r[3] ^ s_r.question_r[2]};
      end
    end
  end

  // The current question stays latched until the next advance.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{question_r: QAWD_QUESTION_RST};
    end else begin
      s_r <= s_nxt; // RULE21
    end
  end

  assign question = s_r.question_r; // RULE1
  assign expected = QAWD_ANS_TBL[s_r.question_r][{ans_index, 3'b000} +: 8]; // RULE22 RULE26
endmodule
`default_nettype wire

/* File: hdl/qawd_spi_rx.sv */
// Serial host port: frames answer writes and question reads, detects frame faults.
`timescale 1ns/1ps
`default_nettype none
module qawd_spi_rx
  import qawd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [3:0] question,
  output logic miso,
  output logic miso_oe,
  output logic qread_evt,
  output logic ans_evt,
  output logic [7:0] ans_byte,
  output logic fault_evt
);
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic mosi_m;
    logic mosi_s;
    logic [15:0] shift_r;
    logic [4:0] bits_r;
    logic [7:0] tx_r;
    logic miso_r;
    logic qrd_r;
    logic ans_r;
    logic [7:0] byte_r;
    logic fault_r;
  } qawd_spi_s;

  qawd_spi_s s_r;
  qawd_spi_s s_nxt;
  logic rise;
  logic fall;
  logic [15:0] sh;

  // Pins pass two flops; edges are found on the second stage only.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_m = sclk;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.cs_m = cs_n;
    s_nxt.cs_s = s_r.cs_m;
    s_nxt.cs_d = s_r.cs_s;
    s_nxt.mosi_m = mosi;
    s_nxt.mosi_s = s_r.mosi_m;
    s_nxt.qrd_r = 1'b0;
    s_nxt.ans_r = 1'b0;
    s_nxt.fault_r = 1'b0;
    rise = s_r.sclk_s & ~s_r.sclk_d & ~s_r.cs_s;
    fall = ~s_r.sclk_s & s_r.sclk_d & ~s_r.cs_s;
    sh = {s_r.shift_r[14:0], s_r.mosi_s};
    if (~s_r.cs_s & s_r.cs_d) begin
      s_nxt.bits_r = 5'h00;
      s_nxt.tx_r = 8'h00;
      s_nxt.miso_r = 1'b0;
    end else if (rise) begin
      s_nxt.shift_r = sh;
      if (s_r.bits_r != 5'h1F) begin
        s_nxt.bits_r = s_r.bits_r + 5'h01;
      end
      if (s_r.bits_r == QAWD_HDR_BITS - 5'h01 && !sh[QAWD_WR_BIT]
          && sh[6:0] == QAWD_ADDR_QUESTION) begin
        s_nxt.tx_r = {4'h0, question};
      end
    end else if (fall && s_r.bits_r >= QAWD_HDR_BITS) begin
      s_nxt.miso_r = s_r.tx_r[7];
      s_nxt.tx_r = {s_r.tx_r[6:0], 1'b0};
    end
    // Frame close: only a whole frame yields an event, anything else is a fault.
    if (s_r.cs_s & ~s_r.cs_d) begin
      s_nxt.miso_r = 1'b0;
      if (s_r.bits_r == QAWD_FRAME_BITS) begin
        if (s_r.shift_r[15] && s_r.shift_r[14:8] == QAWD_ADDR_ANSWER) begin
          s_nxt.ans_r = 1'b1;
          s_nxt.byte_r = s_r.shift_r[7:0];
        end
        if (!s_r.shift_r[15] && s_r.shift_r[14:8] == QAWD_ADDR_QUESTION) begin
          s_nxt.qrd_r = 1'b1; // RULE2
        end
      end else begin
        s_nxt.fault_r = 1'b1; // RULE2
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{sclk_m: 1'b0, sclk_s: 1'b0, sclk_d: 1'b0, cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1,
               mosi_m: 1'b0, mosi_s: 1'b0, shift_r: 16'h0000, bits_r: 5'h00, tx_r: 8'h00,
               miso_r: 1'b0, qrd_r: 1'b0, ans_r: 1'b0, byte_r: 8'h00, fault_r: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign miso = s_r.miso_r;
  assign miso_oe = ~s_r.cs_s;
  assign qread_evt = s_r.qrd_r;
  assign ans_evt = s_r.ans_r;
  assign ans_byte = s_r.byte_r;
  assign fault_evt = s_r.fault_r;
endmodule
`default_nettype wire

/* File: tb/qawd_spi_host.sv */
// Serial host model that frames answer writes and question reads toward the sequencer.
`timescale 1ns/1ps
`default_nettype none
module qawd_spi_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // Idle bus: serial clock stands low and the frame is deselected.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Sends the top nbits of w, MSB first, with a 96 ns serial period, and returns read bits.
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      repeat (4) @(posedge clk);
      mosi <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rd[i] = miso;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // A released data line does not keep its last level.
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_qa_watchdog_sequencer.sv */
// Self-checking bench for the question-and-answer watchdog sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_qa_watchdog_sequencer;
  import qawd_pkg::*;
  localparam int unsigned STEP = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic diag = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_single = 1'b0;
  logic [7:0] cfg_first = 8'h00;
  logic [4:0] cfg_second = 5'h00;
  logic software_write_lock_cmd = 1'b0;
  logic status_clr = 1'b0;
  wire logic sclk, cs_n, mosi, miso, miso_oe;
  // The host sees a pulled-up data line whenever the sequencer leaves it undriven.
  wire logic miso_pin = miso_oe ? miso : 1'b1;
  logic [3:0] question, tally;
  logic [1:0] ans_idx;
  logic f_err, f_early, f_seq, f_to, in_w2, mode_single, locked, run_start, qread_evt, spi_fault;
  logic [7:0] first_len;
  logic [4:0] second_len;
  logic [15:0] rd;
  logic prev_w2 = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_qread = 0;
  int n_fault = 0;
  longint t_run = 0;
  longint t_w2 = 0;
  logic [15:0] w1_len = 16'h0000;
  logic [15:0] w2_len = 16'h0000;

  // System clock of 8 ns period.
  always #4 clk_sys = ~clk_sys;

  qawd_top #(.STEP_CYCLES(STEP)) dut_u (
    .CLK_SYS(clk_sys), .RESETN(rst_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .DIAG_STATE(diag), .CFG_WR(cfg_wr),
    .CFG_MODE_SINGLE(cfg_single), .CFG_FIRST_LEN(cfg_first), .CFG_SECOND_LEN(cfg_second),
    .SOFTWARE_WRITE_LOCK_CMD_CMD(software_write_lock_cmd), .STATUS_CLR(status_clr), .QUESTION(question),
    .ANSWER_INDEX(ans_idx), .FAIL_TALLY(tally), .FLAG_ANSW_ERR(f_err),
    .FLAG_ANSW_EARLY(f_early), .FLAG_SEQ_ERR(f_seq), .FLAG_TIME_OUT(f_to),
    .IN_SECOND_WINDOW(in_w2), .MODE_SINGLE(mode_single), .CFG_LOCKED(locked),
    .FIRST_LEN(first_len), .SECOND_LEN(second_len), .RUN_START(run_start),
    .QREAD_EVT(qread_evt), .SPI_FAULT(spi_fault)
  );

  qawd_spi_host host_u (.clk(clk_sys), .miso(miso_pin), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  // Counts event pulses, measures window lengths in cycles and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    prev_w2 <= in_w2;
    if (qread_evt === 1'b1) n_qread <= n_qread + 1;
    if (spi_fault === 1'b1) n_fault <= n_fault + 1;
    if (run_start === 1'b1) begin
      t_run <= $time;
      w2_len <= 16'(($time - t_w2) / 8);
    end
    if (in_w2 === 1'b1 && prev_w2 === 1'b0) begin
      t_w2 <= $time;
      w1_len <= 16'(($time - t_run) / 8);
    end
    if (cyc == 40000) begin
      n_fail++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compares a seen value with its expectation.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Presents one configuration write pulse; returns after the update edge.
  task automatic cfg(input logic s, input logic [7:0] f, input logic [4:0] sec);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_single <= s;
    cfg_first <= f;
    cfg_second <= sec;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
  endtask

  // Writes one answer byte and waits until it has taken effect.
  task automatic answer(input logic [7:0] b);
    host_u.xfer({1'b1, QAWD_ADDR_ANSWER, b}, 16, rd);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Reads the question register and compares the returned value.
  task automatic qread(input logic [3:0] q);
    host_u.xfer({1'b0, QAWD_ADDR_QUESTION, 8'h00}, 16, rd);
    check(rd[7:0], 16'({4'h0, q}));
  endtask

  // Waits, bounded, for the second window or a run start, then one clock for the lengths.
  task automatic wait_for(input logic want_w2);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      #1;
      if ((want_w2 && in_w2 === 1'b1) || (!want_w2 && run_start === 1'b1)) break;
    end
    @(posedge clk_sys);
    #1;
  endtask

  // Main sequence of scenarios.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(16'({question, ans_idx, tally}), 16'h035);
    check(16'({first_len, 3'h0, second_len}), 16'h0F07);
    check(16'({miso_oe, mode_single, f_err, f_early, f_seq, f_to}), 16'h0);
    cfg(1'b0, 8'h3F, 5'h0F);
    check(16'({run_start, first_len, second_len}), 16'h27EF);
    check(16'({ans_idx, tally}), 16'h36);
    qread(4'h0);
    check(16'(n_qread), 16'h1);
    answer(8'hFF);
    check(16'(ans_idx), 16'h2);
    qread(4'h0);
    answer(8'h0F);
    check(16'(ans_idx), 16'h1);
    answer(8'hF0);
    check(16'({ans_idx, in_w2}), 16'h0);
    wait_for(1'b1);
    check(w1_len, 16'(64 * STEP));
    answer(8'h00);
    check(16'({question, ans_idx, tally}), 16'h075);
    check(16'(f_err), 16'h0);
    qread(4'h1);
    answer(8'hB0);
    answer(8'h00);
    check(16'({f_err, ans_idx}), 16'h5);
    wait_for(1'b0);
    #8;
    check(16'({f_to, f_seq, question, tally}), 16'h316);
    check(w2_len, 16'(16 * STEP));
    @(posedge clk_sys);
    status_clr <= 1'b1;
    @(posedge clk_sys);
    status_clr <= 1'b0;
    #1;
    check(16'({f_err, f_early, f_seq, f_to}), 16'h0);
    host_u.xfer({1'b1, QAWD_ADDR_ANSWER, 8'hB0}, 15, rd);
    repeat (2) @(posedge clk_sys);
    check(16'({n_fault[3:0], 2'h0, ans_idx}), 16'h13);
    diag <= 1'b0;
    cfg(1'b1, 8'h3F, 5'h0F);
    check(16'(mode_single), 16'h0);
    diag <= 1'b1;
    cfg(1'b1, 8'h3F, 5'h0F);
    check(16'({mode_single, ans_idx, tally}), 16'h057);
    answer(8'hBF);
    check(16'({f_early, ans_idx}), 16'h5);
    wait_for(1'b1);
    answer(8'hBF);
    check(16'({question, tally}), 16'h18);
    wait_for(1'b1);
    check(w1_len, 16'(64 * STEP));
    answer(8'hBF);
    check(16'({question, ans_idx, tally}), 16'h097);
    // Nine configuration changes drive the tally into its upper limit.
    for (int k = 0; k < 9; k++) cfg(1'b1, 8'h3F, 5'(k));
    check(16'({tally, 3'h0, second_len}), 16'hF08);
    @(posedge clk_sys);
    software_write_lock_cmd <= 1'b1;
    @(posedge clk_sys);
    software_write_lock_cmd <= 1'b0;
    cfg(1'b0, 8'h10, 5'h03);
    check(16'({locked, mode_single, first_len}), 16'h33F);
    results();
  end
endmodule
`default_nettype wire
